//--- design/dual_ptr_top.sv
// Auxiliary control register and dual pointer select behind an AXI4-Lite slave.
// Assumes a master with one write and one read outstanding; fuse is an async pin.
//
// Added by the designer: the AXI4-Lite interface to the registers.
module dual_ptr_top (
  // Clock, reset, enable
  input  wire logic                              i_clk,
  input  wire logic                              i_reset,
  input  wire logic                              i_ce,
  // AXI4-Lite write
  input  wire logic [dual_ptr_pkg::ADDR_W-1:0]   i_axi_awaddr,
  input  wire logic                              i_axi_awvalid,
  output      logic                              o_axi_awready,
  input  wire logic [31:0]                       i_axi_wdata,
  input  wire logic [3:0]                        i_axi_wstrb,
  input  wire logic                              i_axi_wvalid,
  output      logic                              o_axi_wready,
  output      logic [1:0]                        o_axi_bresp,
  output      logic                              o_axi_bvalid,
  input  wire logic                              i_axi_bready,
  // AXI4-Lite read
  input  wire logic [dual_ptr_pkg::ADDR_W-1:0]   i_axi_araddr,
  input  wire logic                              i_axi_arvalid,
  output      logic                              o_axi_arready,
  output      logic [31:0]                       o_axi_rdata,
  output      logic [1:0]                        o_axi_rresp,
  output      logic                              o_axi_rvalid,
  input  wire logic                              i_axi_rready,
  // Fuse and code space
  input  wire logic                              i_boot_jump_fuse,
  input  wire logic [dual_ptr_pkg::PTR_W-1:0]    i_code_addr,
  // Status outputs
  output      logic [dual_ptr_pkg::PTR_W-1:0]    o_ext_addr,
  output      logic                              o_boot_rom_sel,
  output      logic                              o_pointer_select,
  output      logic                              o_boot_map_enable
);
  import dual_ptr_pkg::*;

  typedef struct packed {
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              sel;
    logic              flag;
    logic              boot_en;
    logic              fuse_s1;
    logic              fuse_s2;
    logic [1:0]        fuse_wait;
    logic [PTR_W-1:0]  ext_addr;
    logic              boot_sel;
  } state_s;

  state_s           st;
  state_s           next_st;
  logic             wr_aux;
  logic             wr_cmd;
  logic             aux_fire;
  logic             cmd_fire;
  logic             inc_aux_fire;
  logic             boot_hit;
  logic [7:0]       aux_now;
  logic [7:0]       aux_inc;
  logic [PTR_W-1:0] active_ptr;
  reg_e             wr_id;
  reg_e             rd_id;

  ptr_if pbus ();

  function automatic reg_e decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] word;
    word = {addr[ADDR_W-1:2], 2'h0};
    if (word == AUX_ADDR) return REG_AUX;
    else if (word == PTR0_ADDR) return REG_PTR0;
    else if (word == PTR1_ADDR) return REG_PTR1;
    else if (word == CMD_ADDR) return REG_CMD;
    else return REG_NONE;
  endfunction : decode

  // [RL3] Bit 2 and reserved bits read as zero
  function automatic logic [7:0] aux_byte(input logic sel, input logic flag, input logic boot);
    logic [7:0] v;
    v = 8'h00;
    v[SEL_BIT]  = sel;
    v[FLAG_BIT] = flag;
    v[BOOT_BIT] = boot;
    v[ZERO_BIT] = 1'b0;
    return v;
  endfunction : aux_byte

  assign aux_now    = aux_byte(st.sel, st.flag, st.boot_en);
  assign aux_inc    = aux_now + AUX_STEP;
  // [RL2] Select bit picks the pointer
  assign active_ptr = st.sel ? pbus.ptr1 : pbus.ptr0;
  assign boot_hit   = st.boot_en && (i_code_addr >= BOOT_BASE);
  assign wr_id      = decode(st.aw_addr);
  assign rd_id      = decode(i_axi_araddr);

  always_comb begin
    next_st = st;
    wr_aux  = 1'b0;
    wr_cmd  = 1'b0;
    // Fuse pin crosses in on two flops
    next_st.fuse_s1 = i_boot_jump_fuse;
    next_st.fuse_s2 = st.fuse_s1;
    if (st.fuse_wait != 2'h0) next_st.fuse_wait = st.fuse_wait - 2'h1;
    // [RL1] Selected pointer drives the address
    next_st.ext_addr = active_ptr;
    // [RL4] Boot ROM window decode
    next_st.boot_sel = boot_hit;

    if (i_axi_awvalid && st.awready) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = i_axi_awaddr;
    end
    if (i_axi_wvalid && st.wready) begin
      next_st.w_got  = 1'b1;
      next_st.w_data = i_axi_wdata;
      next_st.w_strb = i_axi_wstrb;
    end
    if (st.bvalid && i_axi_bready) next_st.bvalid = 1'b0;
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = (wr_id == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      // Pointer registers are read only; loads go through the command word
      if (wr_id == REG_AUX && st.w_strb[0]) wr_aux = 1'b1;
      else if (wr_id == REG_CMD && st.w_strb[0]) wr_cmd = 1'b1;
    end
    next_st.awready = !next_st.aw_got;
    next_st.wready  = !next_st.w_got;

    if (st.arready && i_axi_arvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      if (rd_id == REG_AUX) next_st.rdata = {24'h00_0000, aux_now};
      else if (rd_id == REG_PTR0) next_st.rdata = {16'h0000, pbus.ptr0};
      else if (rd_id == REG_PTR1) next_st.rdata = {16'h0000, pbus.ptr1};
      else if (rd_id == REG_CMD) next_st.rdata = 32'h0000_0000;
      else begin
        next_st.rdata = 32'h0000_0000;
        next_st.rresp = RESP_SLVERR;
      end
    end else if (st.rvalid && i_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;

    // [RL5] Flag is plain storage
    if (wr_aux) begin
      next_st.sel     = st.w_data[SEL_BIT];
      next_st.flag    = st.w_data[FLAG_BIT];
      next_st.boot_en = st.w_data[BOOT_BIT];
    end
    // [RL8] Increment flips select via true add
    if (wr_cmd && st.w_data[CMD_INC_AUX]) begin
      next_st.sel     = aux_inc[SEL_BIT];
      next_st.flag    = aux_inc[FLAG_BIT];
      next_st.boot_en = aux_inc[BOOT_BIT];
    end
    // [RL7] Boot map bit from the fuse once synced
    if (st.fuse_wait == 2'h1) next_st.boot_en = st.fuse_s2;
  end

  assign aux_fire     = wr_aux && i_ce;
  assign cmd_fire     = wr_cmd && i_ce;
  assign inc_aux_fire = cmd_fire && st.w_data[CMD_INC_AUX];

  // Pointer operations use the select value before any toggle in the same command
  assign pbus.sel   = st.sel;
  assign pbus.load  = cmd_fire && st.w_data[CMD_LOAD_PTR];
  assign pbus.inc   = cmd_fire && st.w_data[CMD_INC_PTR] && !st.w_data[CMD_LOAD_PTR];
  assign pbus.value = st.w_data[LOAD_LSB +: PTR_W];

  ptr_bank #(
    .WIDTH (PTR_W)
  ) u_bank (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .bus     (pbus)
  );

  // [RL7] Reset clears select; fuse load follows
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st           <= '0;
      st.awready   <= 1'b1;
      st.wready    <= 1'b1;
      st.arready   <= 1'b1;
      st.fuse_wait <= FUSE_WAIT_INIT;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_axi_awready     = st.awready;
  assign o_axi_wready      = st.wready;
  assign o_axi_bresp       = st.bresp;
  assign o_axi_bvalid      = st.bvalid;
  assign o_axi_arready     = st.arready;
  assign o_axi_rdata       = st.rdata;
  assign o_axi_rresp       = st.rresp;
  assign o_axi_rvalid      = st.rvalid;
  assign o_ext_addr        = st.ext_addr;
  assign o_boot_rom_sel    = st.boot_sel;
  assign o_pointer_select  = st.sel;
  assign o_boot_map_enable = st.boot_en;

  a_ext_addr_follow: assert property (@(posedge i_clk) disable iff (i_reset) // [RL1]
    i_ce |=> (o_ext_addr == $past(active_ptr)))
    else $error("external address is not the selected pointer");

  a_sel_from_write: assert property (@(posedge i_clk) disable iff (i_reset) // [RL2]
    (aux_fire && st.fuse_wait != 2'h1) |=> (o_pointer_select == $past(st.w_data[SEL_BIT])))
    else $error("select bit did not take the written value");

  a_inc_keeps_flag: assert property (@(posedge i_clk) disable iff (i_reset) // [RL3]
    inc_aux_fire |=> ($stable(st.flag) && (o_axi_rdata[ZERO_BIT] == 1'b0 || !o_axi_rvalid
                      || $past(rd_id) != REG_AUX)))
    else $error("increment carried into the user flag");

  a_boot_window: assert property (@(posedge i_clk) disable iff (i_reset) // [RL4]
    i_ce |=> (o_boot_rom_sel == ($past(st.boot_en) && ($past(i_code_addr) >= BOOT_BASE))))
    else $error("boot ROM window decode wrong");

  a_flag_stores: assert property (@(posedge i_clk) disable iff (i_reset) // [RL5]
    aux_fire |=> (st.flag == $past(st.w_data[FLAG_BIT])))
    else $error("user flag did not store the written value");

  a_reset_select: assert property (@(posedge i_clk) // [RL7]
    $past(i_reset) && !i_reset |-> (!o_pointer_select && st.fuse_wait == FUSE_WAIT_INIT))
    else $error("select bit not clear after reset");

  a_fuse_capture: assert property (@(posedge i_clk) disable iff (i_reset) // [RL7]
    (i_ce && st.fuse_wait == 2'h1) |=> (o_boot_map_enable == $past(st.fuse_s2)))
    else $error("boot map bit not loaded from the fuse");

  a_inc_toggles: assert property (@(posedge i_clk) disable iff (i_reset) // [RL8]
    (inc_aux_fire && st.fuse_wait != 2'h1) |=> (o_pointer_select != $past(st.sel)))
    else $error("increment did not toggle the select bit");
endmodule : dual_ptr_top

//--- inc/dual_ptr_pkg.sv
// Constants, register map and types for the dual data pointer block.
// Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
// How it works
// [RL1] Two separate 16-bit pointers exist and the selected one drives the external data address.
// [RL2] Bit 0 of the auxiliary register selects pointer zero when clear and pointer one when set.
// [RL3] Bit 2 reads as zero and ignores writes, so an increment only flips the select bit.
// [RL4] With bit 5 set the boot ROM appears in code space F800h to 0FFFFh, otherwise it is gone.
// [RL5] Bit 3 is a free software flag that steers nothing else.
// [RL6] Software keeps reserved bits 7, 6, 4 and 1 at zero, and their read value means nothing.
// [RL7] Reset clears the select bit and bit 2 and loads the boot map bit from the boot fuse.
// [RL8] Incrementing the auxiliary register flips the select bit instead of forcing a value.
// [RL9] Pointer loads and increments touch only the selected pointer.
package dual_ptr_pkg;
  localparam int ADDR_W = 12;
  localparam int PTR_W  = 16;

  localparam logic [7:0]        AUX_INDEX = 8'ha2;
  localparam logic [ADDR_W-1:0] AUX_ADDR  = {2'h0, AUX_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] PTR0_ADDR = 12'h290;
  localparam logic [ADDR_W-1:0] PTR1_ADDR = 12'h294;
  localparam logic [ADDR_W-1:0] CMD_ADDR  = 12'h298;

  localparam int SEL_BIT  = 0;
  localparam int ZERO_BIT = 2;
  localparam int FLAG_BIT = 3;
  localparam int BOOT_BIT = 5;

  localparam int CMD_INC_AUX  = 0;
  localparam int CMD_INC_PTR  = 1;
  localparam int CMD_LOAD_PTR = 2;
  localparam int LOAD_LSB     = 16;

  localparam logic [PTR_W-1:0] BOOT_BASE      = 16'hf800;
  localparam logic [1:0]       FUSE_WAIT_INIT = 2'h3;
  localparam logic [1:0]       RESP_OKAY      = 2'h0;
  localparam logic [1:0]       RESP_SLVERR    = 2'h2;
  localparam logic [7:0]       AUX_STEP       = 8'h01;
  localparam logic [PTR_W-1:0] PTR_STEP       = 16'h0001;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_AUX,
    REG_PTR0,
    REG_PTR1,
    REG_CMD
  } reg_e;
endpackage : dual_ptr_pkg

//--- inc/ptr_if.sv
// Carrier between the register logic and the pointer bank.
// Assumes both ends run on the same clock.
interface ptr_if;
  import dual_ptr_pkg::*;
  logic             sel;
  logic             load;
  logic             inc;
  logic [PTR_W-1:0] value;
  logic [PTR_W-1:0] ptr0;
  logic [PTR_W-1:0] ptr1;

  modport bank (input sel, input load, input inc, input value, output ptr0, output ptr1);
  modport ctrl (output sel, output load, output inc, output value, input ptr0, input ptr1);
endinterface : ptr_if

//--- design/ptr_bank.sv
// Two data pointers, changed only through the selected one.
// Assumes load and inc are already gated by the clock enable.
module ptr_bank #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Pointer control
  ptr_if.bank       bus
);
  import dual_ptr_pkg::*;

  typedef struct packed {
    logic [PTR_W-1:0] ptr0;
    logic [PTR_W-1:0] ptr1;
  } state_s;

  state_s st;
  state_s next_st;

  if (WIDTH != PTR_W) begin : g_width_check
    $error("ptr_bank WIDTH must equal the carrier pointer width");
  end

  always_comb begin
    next_st = st;
    // [RL9] Selected pointer only
    if (bus.load) begin
      if (bus.sel) next_st.ptr1 = bus.value;
      else next_st.ptr0 = bus.value;
    end else if (bus.inc) begin
      if (bus.sel) next_st.ptr1 = st.ptr1 + PTR_STEP;
      else next_st.ptr0 = st.ptr0 + PTR_STEP;
    end
  end

  // [RL1] Two independent registers
  always_ff @(posedge i_clk) begin
    if (i_reset) st <= '0;
    else st <= next_st;
  end

  assign bus.ptr0 = st.ptr0;
  assign bus.ptr1 = st.ptr1;

  a_unsel_ptr_hold: assert property (@(posedge i_clk) disable iff (i_reset) // [RL9]
    (bus.load || bus.inc) |=> (($past(bus.sel) ? st.ptr0 : st.ptr1) ==
                                ($past(bus.sel) ? $past(st.ptr0) : $past(st.ptr1))))
    else $error("unselected pointer changed");

  a_load_lands: assert property (@(posedge i_clk) disable iff (i_reset) // [RL1]
    (bus.load && !bus.sel) |=> (st.ptr0 == $past(bus.value)))
    else $error("pointer zero did not take the load value");
endmodule : ptr_bank

//--- verif/dual_data_pointer_aux_reg_test.sv
// Self-checking bench for the dual pointer block over AXI4-Lite.
// Assumes the register map and command layout of the pointer package.
module dual_data_pointer_aux_reg_test import dual_ptr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              i_clk, i_reset, i_ce, i_boot_jump_fuse;
  logic [ADDR_W-1:0] i_axi_awaddr, i_axi_araddr;
  logic [31:0]       i_axi_wdata, o_axi_rdata;
  logic [3:0]        i_axi_wstrb;
  logic              i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_arvalid, i_axi_rready;
  logic              o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
  logic [1:0]        o_axi_bresp, o_axi_rresp;
  logic [PTR_W-1:0]  i_code_addr, o_ext_addr;
  logic              o_boot_rom_sel, o_pointer_select, o_boot_map_enable;
  int                n_fail, total_checks;

  dual_ptr_top dut_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_axi_awaddr(i_axi_awaddr), .i_axi_awvalid(i_axi_awvalid), .o_axi_awready(o_axi_awready),
    .i_axi_wdata(i_axi_wdata), .i_axi_wstrb(i_axi_wstrb), .i_axi_wvalid(i_axi_wvalid),
    .o_axi_wready(o_axi_wready), .o_axi_bresp(o_axi_bresp), .o_axi_bvalid(o_axi_bvalid),
    .i_axi_bready(i_axi_bready), .i_axi_araddr(i_axi_araddr), .i_axi_arvalid(i_axi_arvalid),
    .o_axi_arready(o_axi_arready), .o_axi_rdata(o_axi_rdata), .o_axi_rresp(o_axi_rresp),
    .o_axi_rvalid(o_axi_rvalid), .i_axi_rready(i_axi_rready),
    .i_boot_jump_fuse(i_boot_jump_fuse), .i_code_addr(i_code_addr),
    .o_ext_addr(o_ext_addr), .o_boot_rom_sel(o_boot_rom_sel),
    .o_pointer_select(o_pointer_select), .o_boot_map_enable(o_boot_map_enable)
  );

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic end_sim;
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Holds each channel until its own handshake edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w  = 1'b1;
    @(posedge i_clk);
    i_axi_awaddr  <= a;
    i_axi_wdata   <= d;
    i_axi_wstrb   <= s;
    i_axi_awvalid <= 1'b1;
    i_axi_wvalid  <= 1'b1;
    i_axi_bready  <= 1'b1;
    // Only the watchdog ends a wait that never sees its answer
    forever begin
      @(posedge i_clk);
      if (aw && o_axi_awready === 1'b1) begin
        aw = 1'b0;
        i_axi_awvalid <= 1'b0;
      end
      if (w && o_axi_wready === 1'b1) begin
        w = 1'b0;
        i_axi_wvalid <= 1'b0;
      end
      if (o_axi_bvalid === 1'b1) break;
    end
    i_axi_bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, o_axi_bresp});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge i_clk);
    i_axi_araddr  <= a;
    i_axi_arvalid <= 1'b1;
    i_axi_rready  <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (o_axi_arready === 1'b1) i_axi_arvalid <= 1'b0;
      if (o_axi_rvalid === 1'b1) break;
    end
    i_axi_rready <= 1'b0;
    check("rdata", ed, o_axi_rdata);
    check("rresp", {30'h0, er}, {30'h0, o_axi_rresp});
  endtask : rd

  // Lets the one-cycle output lag pass, then samples mid-cycle
  task automatic settle;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
  endtask : settle

  // Code address moves on a rising edge, then the lag is waited out
  task automatic code_at(input logic [PTR_W-1:0] a);
    @(posedge i_clk);
    i_code_addr <= a;
    settle();
  endtask : code_at

  task automatic do_reset(input logic fuse);
    @(posedge i_clk);
    i_reset          <= 1'b1;
    i_boot_jump_fuse <= fuse;
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    check("idle_bus", 32'h0000_001c, {27'h0, o_axi_awready, o_axi_wready, o_axi_arready,
                                      o_axi_bvalid, o_axi_rvalid});
  endtask : do_reset

  initial begin
    repeat (3000) @(posedge i_clk);
    n_fail++;
    end_sim();
  end

  initial begin
    n_fail = 0;
    total_checks = 0;
    {i_reset, i_ce, i_boot_jump_fuse} = 3'b111;
    {i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_arvalid, i_axi_rready} = 5'h00;
    i_axi_awaddr = 12'h000;
    i_axi_araddr = 12'h000;
    i_axi_wdata  = 32'h0000_0000;
    i_axi_wstrb  = 4'hf;
    i_code_addr  = 16'h0000;
    do_reset(1'b1);
    rd(AUX_ADDR, 32'h0000_0020, RESP_OKAY);
    settle();
    check("boot_map", 32'h1, {31'h0, o_boot_map_enable});
    check("select", 32'h0, {31'h0, o_pointer_select});
    code_at(16'hf800);
    check("boot_sel_f800", 32'h1, {31'h0, o_boot_rom_sel});
    // Enable low must freeze the window decode
    @(posedge i_clk);
    i_ce <= 1'b0;
    code_at(16'hf7ff);
    check("ce_freeze", 32'h1, {31'h0, o_boot_rom_sel});
    @(posedge i_clk);
    i_ce <= 1'b1;
    settle();
    check("boot_sel_f7ff", 32'h0, {31'h0, o_boot_rom_sel});
    code_at(16'hffff);
    check("boot_sel_ffff", 32'h1, {31'h0, o_boot_rom_sel});
    wr(AUX_ADDR, 32'h0000_000d, 4'hf, RESP_OKAY);
    rd(AUX_ADDR, 32'h0000_0009, RESP_OKAY);
    settle();
    check("select_set", 32'h1, {31'h0, o_pointer_select});
    check("boot_sel_off", 32'h0, {31'h0, o_boot_rom_sel});
    wr(AUX_ADDR, 32'h0000_0000, 4'he, RESP_OKAY);
    rd(AUX_ADDR, 32'h0000_0009, RESP_OKAY);
    wr(CMD_ADDR, 32'h1234_0004, 4'hf, RESP_OKAY);
    rd(PTR0_ADDR, 32'h0000_0000, RESP_OKAY);
    rd(PTR1_ADDR, 32'h0000_1234, RESP_OKAY);
    settle();
    check("ext_ptr1", 32'h0000_1234, {16'h0, o_ext_addr});
    wr(CMD_ADDR, 32'h0000_0003, 4'hf, RESP_OKAY);
    rd(AUX_ADDR, 32'h0000_0008, RESP_OKAY);
    rd(PTR1_ADDR, 32'h0000_1235, RESP_OKAY);
    settle();
    check("ext_ptr0", 32'h0000_0000, {16'h0, o_ext_addr});
    wr(CMD_ADDR, 32'habcd_0006, 4'hf, RESP_OKAY);
    wr(CMD_ADDR, 32'h0000_0002, 4'hf, RESP_OKAY);
    rd(PTR0_ADDR, 32'h0000_abce, RESP_OKAY);
    rd(PTR1_ADDR, 32'h0000_1235, RESP_OKAY);
    wr(CMD_ADDR, 32'h0000_0001, 4'hf, RESP_OKAY);
    rd(AUX_ADDR, 32'h0000_0009, RESP_OKAY);
    settle();
    check("ext_toggle", 32'h0000_1235, {16'h0, o_ext_addr});
    wr(12'h2a0, 32'h0000_0001, 4'hf, RESP_SLVERR);
    rd(12'h2a0, 32'h0000_0000, RESP_SLVERR);
    rd(CMD_ADDR, 32'h0000_0000, RESP_OKAY);
    do_reset(1'b0);
    rd(AUX_ADDR, 32'h0000_0000, RESP_OKAY);
    rd(PTR1_ADDR, 32'h0000_0000, RESP_OKAY);
    settle();
    check("boot_map_off", 32'h0, {31'h0, o_boot_map_enable});
    end_sim();
  end
endmodule : dual_data_pointer_aux_reg_test
